//--- brf_byte_pack.sv
`timescale 1ns/1ps
module brf_byte_pack (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        clear,
	input  wire logic [7:0]  byte_in,
	input  wire logic        byte_valid,
	input  wire logic        flush,
	output logic      [31:0] quad_out,
	output logic             quad_valid
);
	logic [1:0]  lane;
	logic [1:0]  next_lane;
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic        next_quad_valid;
	logic [31:0] next_quad_out;

	always_comb begin
		next_lane       = lane;
		next_acc        = acc;
		next_quad_valid = 1'b0;
		next_quad_out   = quad_out;
		if (clear) begin
			next_lane = 2'h0;
			next_acc  = 32'h0;
		end else if (byte_valid) begin
			// first byte lands in byte 0 (msb lane)
			next_acc[31 - 8*lane -: 8] = byte_in;
			next_lane = lane + 2'h1;
			if (lane == 2'h3) begin
				next_quad_valid = 1'b1;
				next_quad_out   = next_acc;
				next_acc        = 32'h0;
			end
		end else if (flush && lane != 2'h0) begin
			next_quad_valid = 1'b1;
			next_quad_out   = acc;
			next_acc        = 32'h0;
			next_lane       = 2'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lane       <= 2'h0;
			acc        <= 32'h0;
			quad_valid <= 1'b0;
			quad_out   <= 32'h0;
		end else if (clk_en) begin
			lane       <= next_lane;
			acc        <= next_acc;
			quad_valid <= next_quad_valid;
			quad_out   <= next_quad_out;
		end
	end
endmodule : brf_byte_pack

//--- brf_device.sv
// What this block does
// - token quadlet first in every response
// - destination id in upper second quadlet
// - response code stored in header
// - read response: length then extended code
// - payload follows extended code quadlet
// - packet complete flag marks final block
// - speed code 00/01/10, 11 undefined
// - token reports packet data quadlet count
// - returned ack code in 5-bit field
// - destination is bus plus node number
// - host matches responses by transaction label
// - retry code new, X, A, B
// - priority zero on cable
// - destination offset quadlet aligned
// - response code meanings, reserved values
// - first payload byte in byte 0
// - zero length writes no payload
// - source id stored in header
`timescale 1ns/1ps
module brf_device (
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	brf_fifo_if.device               fifo,
	input  wire logic                hdr_start,
	input  wire logic                is_read_resp,
	input  wire logic [1:0]          spd,
	input  wire logic [9:0]          dest_bus,
	input  wire logic [5:0]          dest_node,
	input  wire logic [5:0]          tlabel,
	input  wire logic [1:0]          retry_code,
	input  wire logic [15:0]         source_id,
	input  wire logic [3:0]          rcode,
	input  wire logic [15:0]         data_length,
	input  wire logic [15:0]         ext_tcode,
	input  wire logic [4:0]          returned_ack_code,
	input  wire logic [7:0]          byte_in,
	input  wire logic                byte_valid,
	output logic                     byte_ready,
	output logic                     rcode_reserved,
	output logic                     spd_undefined,
	output logic                     busy
);
	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_hdr   = 3'b001,
		st_data  = 3'b010,
		st_flush = 3'b011
	} brf_state_type;

	// transaction code of the response kind
	function automatic logic [3:0] resp_tcode(input logic rd);
		return rd ? brf_pkg::tcode_rd_resp : brf_pkg::tcode_wr_resp;
	endfunction : resp_tcode

	brf_state_type           state;
	brf_state_type           next_state;

	// header words captured at start
	logic [31:0]             hdr [0:4];
	logic [31:0]             next_hdr [0:4];
	logic [2:0]              idx;
	logic [2:0]              next_idx;
	logic [2:0]              n_hdr;
	logic [2:0]              next_n_hdr;
	logic [15:0]             bytes_left;
	logic [15:0]             next_bytes_left;

	// output slot toward the host
	logic [31:0]             data_q;
	logic [31:0]             next_data_q;
	logic                    valid_q;
	logic                    next_valid_q;
	logic                    last_q;
	logic                    next_last_q;

	// packer link
	logic [31:0]             pk_quad;
	logic                    pk_valid;
	logic                    pk_clear;
	logic                    pk_flush;
	logic                    take;
	logic                    byte_take;
	logic [brf_pkg::cnt_w-1:0] nquads;

	assign take       = valid_q && fifo.ready;
	assign fifo.data  = data_q;
	assign fifo.valid = valid_q;
	assign fifo.last  = last_q;
	assign busy       = state != st_idle;
	// a byte is accepted only when the output slot is free, never while frozen
	assign byte_ready = state == st_data && bytes_left != 16'h0 && (!valid_q || take)
		&& !pk_valid && clk_en;
	assign byte_take  = byte_valid && byte_ready;
	assign pk_clear   = hdr_start && state == st_idle;
	assign pk_flush   = state == st_flush;
	assign nquads     = is_read_resp ? brf_pkg::brf_quads(data_length) : '0;

	brf_byte_pack u_pack (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.clear      (pk_clear),
		.byte_in    (byte_in),
		.byte_valid (byte_take),
		.flush      (pk_flush),
		.quad_out   (pk_quad),
		.quad_valid (pk_valid)
	);

	always_comb begin
		next_state      = state;
		next_idx        = idx;
		next_n_hdr      = n_hdr;
		next_bytes_left = bytes_left;
		next_data_q     = data_q;
		next_valid_q    = valid_q && !take;
		next_last_q     = last_q && !take;
		for (int i = 0; i < 5; i++) next_hdr[i] = hdr[i];
		// status outputs follow the live inputs
		rcode_reserved  = brf_pkg::brf_rcode_reserved(rcode);
		spd_undefined   = spd == brf_pkg::brf_spd_und;
		unique case (state)
			st_idle: begin
				if (hdr_start) begin
					next_hdr[0] = '0;
					next_hdr[0][brf_pkg::tok_packet_complete_flag_bit] = 1'b1;
					next_hdr[0][brf_pkg::tok_spd_lsb +: 2] = spd;
					next_hdr[0][brf_pkg::tok_cnt_lsb +: 9] = {1'b0, nquads};
					next_hdr[0][brf_pkg::tok_tcode_lsb +: 4] = resp_tcode(is_read_resp);
					next_hdr[0][brf_pkg::tok_ack_lsb +: 5] = returned_ack_code;
					next_hdr[1] = {dest_bus, dest_node, tlabel, retry_code,
						resp_tcode(is_read_resp), brf_pkg::prio_cable};
					next_hdr[2] = {source_id, rcode, 12'h000};
					// reserved word, zero and so quadlet aligned
					next_hdr[3] = 32'h0;
					next_hdr[4] = {data_length, ext_tcode};
					next_n_hdr  = is_read_resp ? brf_pkg::hdr_quads_rd
						: brf_pkg::hdr_quads_wr;
					next_bytes_left = is_read_resp ? data_length : 16'h0;
					next_idx    = 3'h0;
					next_state  = st_hdr;
				end
			end
			st_hdr: begin
				if (!valid_q || take) begin
					next_data_q  = hdr[idx];
					next_valid_q = 1'b1;
					next_idx     = idx + 3'h1;
					if (idx + 3'h1 == n_hdr) begin
						// last header quadlet ends packet when no payload
						next_last_q = bytes_left == 16'h0;
						next_state  = bytes_left == 16'h0 ? st_idle : st_data;
					end else begin
						next_last_q = 1'b0;
					end
				end
			end
			st_data: begin
				if (byte_take) begin
					next_bytes_left = bytes_left - 16'h1;
					if (bytes_left == 16'h1) next_state = st_flush;
				end
				// a packed quadlet always finds the slot empty
				if (pk_valid) begin
					next_data_q  = pk_quad;
					next_valid_q = 1'b1;
					next_last_q  = 1'b0;
				end
			end
			st_flush: begin
				// the final packed quadlet, padded unless the length is a multiple of 4, closes the packet
				if (pk_valid) begin
					next_data_q  = pk_quad;
					next_valid_q = 1'b1;
					next_last_q  = 1'b1;
					next_state   = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state      <= st_idle;
			idx        <= 3'h0;
			n_hdr      <= 3'h0;
			bytes_left <= 16'h0;
			data_q     <= 32'h0;
			valid_q    <= 1'b0;
			last_q     <= 1'b0;
			for (int i = 0; i < 5; i++) hdr[i] <= 32'h0;
		end else if (clk_en) begin
			// all state holds while clk_en is low
			state      <= next_state;
			idx        <= next_idx;
			n_hdr      <= next_n_hdr;
			bytes_left <= next_bytes_left;
			data_q     <= next_data_q;
			valid_q    <= next_valid_q;
			last_q     <= next_last_q;
			for (int i = 0; i < 5; i++) hdr[i] <= next_hdr[i];
		end
	end
endmodule : brf_device

//--- brf_fifo_assertions.sv
`timescale 1ns/1ps
module brf_fifo_assertions (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] data,
	input wire logic        valid,
	input wire logic        ready,
	input wire logic        last
);
	logic [9:0] idx, next_idx;
	logic [3:0] tcode, next_tcode;
	logic [8:0] cnt, next_cnt;
	// word position within the packet and the token fields it depends on
	always_comb begin
		next_idx = idx;
		next_tcode = tcode;
		next_cnt = cnt;
		if (valid && ready)
			next_idx = last ? 10'h000 : idx + 10'h001;
		if (valid && ready && idx == 10'h000) begin
			next_tcode = data[8:5];
			next_cnt = data[17:9];
		end
	end
	always_ff @(posedge ref_clk) begin
		idx <= sys_rst ? 10'h000 : next_idx;
		tcode <= sys_rst ? 4'h0 : next_tcode;
		cnt <= sys_rst ? 9'h000 : next_cnt;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_hold;
		valid && !ready |=> valid && $stable(data) && $stable(last);
	endproperty
	property p_tok;
		valid && idx == 10'h000 |-> data[31:21] == 11'h000 && data[20] && !data[17] && !last;
	endproperty
	property p_tcode;
		valid && idx == 10'h000 |->
			data[8:5] == brf_pkg::tcode_wr_resp || data[8:5] == brf_pkg::tcode_rd_resp;
	endproperty
	property p_q1;
		valid && idx == 10'h001 |-> data[3:0] == brf_pkg::prio_cable && data[7:4] == tcode && !last;
	endproperty
	property p_q2;
		valid && idx == 10'h002 |->
			data[11:0] == 12'h000 && last == (tcode == brf_pkg::tcode_wr_resp);
	endproperty
	property p_q3;
		valid && idx == 10'h003 |-> data == 32'h0000_0000 && !last;
	endproperty
	property p_len;
		valid && idx == 10'h004 |-> cnt[7:0] == 8'(({1'b0, data[31:16]} + 17'h00003) >> 2);
	endproperty
	property p_end;
		valid && last |->
			idx == ((tcode == brf_pkg::tcode_rd_resp) ? {1'b0, cnt} + 10'h004 : 10'h002);
	endproperty
	a_hold: assert property (p_hold) else $error("fifo word changed while stalled");
	a_tok: assert property (p_tok) else $error("bad token quadlet");
	a_tcode: assert property (p_tcode) else $error("bad token tcode");
	a_q1: assert property (p_q1) else $error("bad second quadlet");
	a_q2: assert property (p_q2) else $error("bad third quadlet");
	a_q3: assert property (p_q3) else $error("reserved quadlet not zero");
	a_len: assert property (p_len) else $error("count does not match length");
	a_end: assert property (p_end) else $error("packet ends at wrong quadlet");
	c_write: cover property (valid && ready && last && idx == 10'h002);
	c_read: cover property (valid && ready && last && idx > 10'h005);
	c_stall: cover property (valid && !ready);
endmodule : brf_fifo_assertions

//--- brf_fifo_if.sv
`timescale 1ns/1ps
interface brf_fifo_if;
	logic [31:0] data;
	logic        valid;
	logic        ready;
	logic        last;
	modport device (output data, output valid, output last, input ready);
	modport host   (input data, input valid, input last, output ready);
endinterface : brf_fifo_if

//--- brf_host.sv
`timescale 1ns/1ps
module brf_host (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	brf_fifo_if.host         fifo,
	input  wire logic        accept,
	input  wire logic [5:0]  expect_label,
	output logic             resp_done,
	output logic             label_match,
	output logic [3:0]       resp_code,
	output logic [4:0]       ack_code,
	output logic [31:0]      payload,
	output logic             payload_valid
);
	logic [2:0]  pos;
	logic [2:0]  next_pos;
	logic        next_resp_done;
	logic        next_label_match;
	logic [3:0]  next_resp_code;
	logic [4:0]  next_ack_code;
	logic [31:0] next_payload;
	logic        next_payload_valid;
	logic        take;

	// nothing is taken while frozen
	assign fifo.ready = accept && clk_en;
	assign take       = fifo.valid && accept;

	always_comb begin
		next_pos           = pos;
		next_resp_done     = 1'b0;
		next_label_match   = label_match;
		next_resp_code     = resp_code;
		next_ack_code      = ack_code;
		next_payload       = payload;
		next_payload_valid = 1'b0;
		if (take) begin
			if (pos == 3'h0) next_ack_code = fifo.data[brf_pkg::tok_ack_lsb +: 5];
			if (pos == 3'h1) begin
				next_label_match = fifo.data[brf_pkg::q1_label_lsb +: 6]
					== expect_label;
			end
			if (pos == 3'h2) next_resp_code = fifo.data[brf_pkg::q2_rcode_lsb +: 4];
			if (pos >= brf_pkg::hdr_quads_rd) begin
				next_payload       = fifo.data;
				next_payload_valid = 1'b1;
			end
			if (pos < brf_pkg::hdr_quads_rd) next_pos = pos + 3'h1;
			if (fifo.last) begin
				next_pos       = 3'h0;
				next_resp_done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pos           <= 3'h0;
			resp_done     <= 1'b0;
			label_match   <= 1'b0;
			resp_code     <= 4'h0;
			ack_code      <= 5'h00;
			payload       <= 32'h0;
			payload_valid <= 1'b0;
		end else if (clk_en) begin
			pos           <= next_pos;
			resp_done     <= next_resp_done;
			label_match   <= next_label_match;
			resp_code     <= next_resp_code;
			ack_code      <= next_ack_code;
			payload       <= next_payload;
			payload_valid <= next_payload_valid;
		end
	end
endmodule : brf_host

//--- brf_pkg.sv
package brf_pkg;
	localparam int          quad_w          = 32;
	localparam int          len_w           = 16;
	localparam int          cnt_w           = 8;
	// token layout
	localparam int          tok_packet_complete_flag_bit  = 20;
	localparam int          tok_spd_lsb     = 18;
	localparam int          tok_cnt_lsb     = 9;
	localparam int          tok_tcode_lsb   = 5;
	localparam int          tok_ack_lsb     = 0;
	// second quadlet
	localparam int          q1_dest_lsb     = 16;
	localparam int          q1_label_lsb    = 10;
	localparam int          q1_retry_lsb    = 8;
	localparam int          q1_tcode_lsb    = 4;
	localparam int          q1_prio_lsb     = 0;
	localparam int          dest_node_w     = 6;
	// third quadlet
	localparam int          q2_src_lsb      = 16;
	localparam int          q2_rcode_lsb    = 12;
	// length quadlet
	localparam int          q4_len_lsb      = 16;
	localparam logic [3:0]  tcode_wr_resp   = 4'h2;
	localparam logic [3:0]  tcode_rd_resp   = 4'h7;
	localparam logic [3:0]  prio_cable      = 4'h0;
	localparam logic [2:0]  hdr_quads_wr    = 3'h3;
	localparam logic [2:0]  hdr_quads_rd    = 3'h5;
	localparam logic [1:0]  addr_align_mask = 2'h3;

	typedef enum logic [1:0] {
		brf_spd_100 = 2'b00,
		brf_spd_200 = 2'b01,
		brf_spd_400 = 2'b10,
		brf_spd_und = 2'b11
	} brf_spd_type;

	typedef enum logic [1:0] {
		brf_rt_new   = 2'b00,
		brf_rt_retry_x = 2'b01,
		brf_rt_retry_a = 2'b10,
		brf_rt_retry_b = 2'b11
	} brf_retry_type;

	typedef enum logic [3:0] {
		brf_rc_complete = 4'h0,
		brf_rc_conflict = 4'h4,
		brf_rc_data     = 4'h5,
		brf_rc_type     = 4'h6,
		brf_rc_address  = 4'h7
	} brf_rcode_type;

	function automatic logic brf_rcode_reserved(input logic [3:0] code);
		return !(code == 4'h0 || (code >= 4'h4 && code <= 4'h7));
	endfunction : brf_rcode_reserved

	function automatic logic [cnt_w-1:0] brf_quads(input logic [len_w-1:0] bytes);
		logic [len_w:0] sum;
		sum = {1'b0, bytes} + 17'h00003;
		return sum[cnt_w+1:2];
	endfunction : brf_quads
endpackage : brf_pkg

//--- test_block_response_receive_format.sv
`timescale 1ns/1ps
module test_block_response_receive_format;
	logic        ref_clk, sys_rst, hdr_start, is_read_resp, byte_valid, accept, stall;
	logic        byte_ready, rcode_reserved, spd_undefined, busy, resp_done, label_match;
	logic        payload_valid;
	logic        clk_en, freeze, en_q;
	logic [1:0]  spd, retry_code;
	logic [3:0]  rcode, resp_code;
	logic [4:0]  returned_ack_code, ack_code;
	logic [5:0]  tlabel, host_label;
	logic [7:0]  byte_in;
	logic [15:0] data_length;
	logic [31:0] payload;
	logic [31:0] got[$];
	logic [31:0] pay[$];
	int          n_errors = 0;
	int          checks = 0;
	brf_fifo_if bus ();
	brf_device u_brf_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .fifo(bus),
		.hdr_start(hdr_start), .is_read_resp(is_read_resp), .spd(spd), .dest_bus(10'h2a5),
		.dest_node(6'h13), .tlabel(tlabel), .retry_code(retry_code), .source_id(16'hc3a1),
		.rcode(rcode), .data_length(data_length), .ext_tcode(16'h5e7b),
		.returned_ack_code(returned_ack_code), .byte_in(byte_in), .byte_valid(byte_valid),
		.byte_ready(byte_ready), .rcode_reserved(rcode_reserved),
		.spd_undefined(spd_undefined), .busy(busy));
	brf_host u_brf_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .fifo(bus),
		.accept(accept), .expect_label(host_label), .resp_done(resp_done),
		.label_match(label_match), .resp_code(resp_code), .ack_code(ack_code),
		.payload(payload), .payload_valid(payload_valid));
	brf_fifo_assertions u_brf_fifo_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.data(bus.data), .valid(bus.valid), .ready(bus.ready), .last(bus.last));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// host side stalls every other cycle when asked
	always @(posedge ref_clk) accept <= #1 (stall ? ~accept : 1'b1);
	// both ends freeze every other cycle of a packet when asked
	always @(posedge ref_clk) clk_en <= #1 !(freeze && busy && clk_en);
	always @(posedge ref_clk) begin
		if (!sys_rst && bus.valid === 1'b1 && bus.ready === 1'b1)
			got.push_back(bus.data);
		// a pulse held over a frozen edge counts once
		if (payload_valid === 1'b1 && en_q === 1'b1)
			pay.push_back(payload);
		en_q = clk_en;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
		checks++;
		if (seen !== expd) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, expd, seen);
		end
	endtask : check
	task automatic finish_test;
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic run_pkt(input logic rd, input logic [15:0] len, input logic [1:0] rt,
		input logic [1:0] sp, input logic [3:0] rc, input logic [5:0] lbl, input logic poke);
		logic [31:0] exp[$];
		logic [31:0] pexp[$];
		logic [31:0] q;
		logic [7:0]  cnt;
		logic [3:0]  tc;
		int          i;
		int          w;
		tc = rd ? brf_pkg::tcode_rd_resp : brf_pkg::tcode_wr_resp;
		cnt = rd ? 8'((17'(len) + 17'h00003) >> 2) : 8'h00;
		exp.push_back({11'h000, 1'b1, sp, 1'b0, cnt, tc, 1'b1, rc});
		exp.push_back({10'h2a5, 6'h13, lbl, rt, tc, 4'h0});
		exp.push_back({16'hc3a1, rc, 12'h000});
		if (rd) begin
			exp.push_back(32'h0000_0000);
			exp.push_back({len, 16'h5e7b});
		end
		for (i = 0; i < cnt; i++) begin
			q = 32'h0000_0000;
			for (w = 0; w < 4; w++)
				if (4 * i + w < len)
					q[31 - 8 * w -: 8] = 8'(4 * i + w + 8'ha0);
			exp.push_back(q);
			pexp.push_back(q);
		end
		got.delete();
		pay.delete();
		@(posedge ref_clk);
		#1;
		is_read_resp = rd;
		spd = sp;
		retry_code = rt;
		rcode = rc;
		returned_ack_code = {1'b1, rc};
		data_length = len;
		tlabel = lbl;
		hdr_start = 1'b1;
		@(posedge ref_clk);
		#1;
		// a second start while busy must be ignored
		hdr_start = poke;
		is_read_resp = ~rd;
		rcode = ~rc;
		@(posedge ref_clk);
		#1;
		hdr_start = 1'b0;
		for (i = 0; i < (rd ? int'(len) : 0); i++) begin
			byte_in = 8'(i + 8'ha0);
			byte_valid = 1'b1;
			w = 0;
			@(negedge ref_clk);
			while (byte_ready !== 1'b1 && w < 300) begin
				@(negedge ref_clk);
				w++;
			end
			@(posedge ref_clk);
			#1;
		end
		byte_valid = 1'b0;
		w = 0;
		do begin
			@(posedge ref_clk);
			#1;
			w++;
		end while (resp_done !== 1'b1 && w < 300);
		check("done", {31'h0, resp_done}, 32'h1);
		@(posedge ref_clk);
		#1;
		check("label", {31'h0, label_match}, {31'h0, lbl == host_label});
		check("rcode", {28'h0, resp_code}, {28'h0, rc});
		check("ack", {27'h0, ack_code}, {27'h1, rc});
		check("quadlets", 32'(got.size()), 32'(exp.size()));
		foreach (exp[k]) check("quadlet", got[k], exp[k]);
		check("payloads", 32'(pay.size()), 32'(pexp.size()));
		foreach (pexp[k]) check("payload", pay[k], pexp[k]);
	endtask : run_pkt
	task automatic t_flags;
		for (int k = 0; k < 16; k++) begin
			rcode = 4'(k);
			spd = 2'(k);
			#1;
			check("reserved", {31'h0, rcode_reserved}, {31'h0, !(k == 0 || (k >= 4 && k <= 7))});
			check("undef", {31'h0, spd_undefined}, {31'h0, k % 4 == 3});
		end
	endtask : t_flags
	task automatic t_write;
		for (int k = 0; k < 4; k++)
			run_pkt(1'b0, 16'(4 * k + 3), 2'(k), 2'(k % 3), 4'(k + 4), 6'(9 * k + 9), 1'b0);
	endtask : t_write
	task automatic t_read;
		run_pkt(1'b1, 16'h0000, 2'h0, 2'h2, 4'h0, 6'h12, 1'b0);
		run_pkt(1'b1, 16'h0001, 2'h1, 2'h1, 4'h5, 6'h12, 1'b0);
		run_pkt(1'b1, 16'h0004, 2'h2, 2'h0, 4'h0, 6'h03, 1'b1);
		stall = 1'b1;
		run_pkt(1'b1, 16'h0007, 2'h3, 2'h2, 4'h7, 6'h12, 1'b0);
		freeze = 1'b1;
		run_pkt(1'b1, 16'h0009, 2'h1, 2'h0, 4'h4, 6'h12, 1'b0);
		freeze = 1'b0;
		stall = 1'b0;
	endtask : t_read
	initial begin
		{sys_rst, hdr_start, is_read_resp, byte_valid, accept, stall, freeze} = 7'h40;
		{en_q, host_label} = 7'h12;
		{spd, retry_code, rcode, returned_ack_code, tlabel, byte_in, data_length} = 43'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		t_flags();
		t_write();
		t_read();
		finish_test();
	end
	initial begin
		#(40 * 20000);
		n_errors++;
		finish_test();
	end
endmodule : test_block_response_receive_format
